// ### verilog/acp_ctrl.sv
// Command acceptance, handshake and protocol class control with APB access.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
module acp_ctrl (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_comreset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [acp_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_exec_done,
	input wire logic i_exec_err,
	input wire logic [31:0] i_pio_rdata,
	output logic o_cmd_valid,
	output acp_pkg::acp_taskfile_s o_cmd,
	output logic [2:0] o_cmd_class,
	output logic o_cmd_hi_prio,
	output logic o_pio_rd,
	output logic o_pio_wr,
	output logic [31:0] o_pio_wdata,
	output logic o_busy,
	output logic o_data_req,
	output logic o_intrq,
	output logic o_abort
);
	acp_pkg::acp_regs_s q;
	acp_pkg::acp_regs_s d;
	logic [2:0] dec_cls;
	logic access;
	logic fire;
	logic fire_wr;
	logic fire_rd;
	logic word_go;
	logic reset_evt;

	// A zero sector count means 256 sectors, as on the classic task file.
	function automatic logic [15:0] sector_words(input logic [15:0] cnt);
		logic [16:0] n;
		n = (cnt[7:0] == 8'h00) ? 17'h0_0100 : {9'h000, cnt[7:0]};
		return 16'(n * acp_pkg::SECT_WORDS);
	endfunction : sector_words

	function automatic logic [31:0] status_word(input acp_pkg::acp_regs_s r);
		logic [31:0] s;
		s = 32'h0000_0000;
		s[acp_pkg::STAT_BUSY_POS] = r.busy;
		s[acp_pkg::STAT_READY_POS] = r.rdy;
		s[acp_pkg::STAT_DREQ_POS] = r.dreq;
		s[acp_pkg::STAT_ERR_POS] = r.err;
		return s;
	endfunction : status_word

	function automatic logic mapped(input logic [acp_pkg::ADDR_W-1:0] a);
		return a == acp_pkg::OFS_FEATURE || a == acp_pkg::OFS_COUNT ||
			a == acp_pkg::OFS_COMMAND || a == acp_pkg::OFS_STATUS ||
			a == acp_pkg::OFS_ALT_STATUS || a == acp_pkg::OFS_INFO ||
			a == acp_pkg::OFS_CONTROL || a == acp_pkg::OFS_DATA;
	endfunction : mapped

	acp_cmd_decode u_decode (
		.i_opcode(q.tf.opcode),
		.i_feature(q.tf.feature),
		.o_class(dec_cls)
	);

	always_comb begin
		d = q;
		d.rdy = 1'h1;
		d.cmd_valid = 1'h0;
		d.pio_rd = 1'h0;
		d.pio_wr = 1'h0;
		d.abort = 1'h0;
		d.pslverr = 1'h0;
		access = i_psel & i_penable;
		// One wait state lets read data come from a flop.
		d.pready = access & ~q.pready;
		fire = access & q.pready;
		fire_wr = fire & i_pwrite;
		fire_rd = fire & ~i_pwrite;
		word_go = 1'h0;
		reset_evt = i_comreset;
		if (d.pready) begin
			d.pslverr = ~mapped(i_paddr);
			unique case (i_paddr)
				acp_pkg::OFS_FEATURE: d.prdata = {16'h0000, q.tf.feature};
				acp_pkg::OFS_COUNT: d.prdata = {16'h0000, q.tf.count};
				acp_pkg::OFS_COMMAND: d.prdata = {24'h00_0000, q.tf.opcode};
				acp_pkg::OFS_STATUS, acp_pkg::OFS_ALT_STATUS:
					d.prdata = status_word(q);
				acp_pkg::OFS_INFO: begin
					d.prdata = {29'h0000_0000, q.cls};
					d.prdata[acp_pkg::INFO_PRIO_POS] = q.hi;
					d.prdata[acp_pkg::INFO_ABORT_POS] =
						q.err & (q.cls == acp_pkg::CLS_NONE);
				end
				acp_pkg::OFS_DATA: d.prdata = (q.st == acp_pkg::ST_PIO &&
					q.cls == acp_pkg::CLS_PIO_IN) ? i_pio_rdata : 32'h0000_0000;
				default: d.prdata = 32'h0000_0000;
			endcase
		end
		if (fire_wr) begin
			unique case (i_paddr)
				acp_pkg::OFS_FEATURE: d.tf.feature = i_pwdata[15:0];
				acp_pkg::OFS_COUNT: d.tf.count = i_pwdata[15:0];
				acp_pkg::OFS_COMMAND: begin
					d.irq = 1'h0;
					// Writes while busy or requesting are dropped.
					if (q.st == acp_pkg::ST_IDLE) begin
						d.tf.opcode = i_pwdata[7:0];
						d.busy = 1'h1;
						d.err = 1'h0;
						d.st = acp_pkg::ST_DECODE;
					end
				end
				acp_pkg::OFS_CONTROL:
					reset_evt = reset_evt | i_pwdata[acp_pkg::CTRL_SRST_POS];
				acp_pkg::OFS_DATA:
					if (q.st == acp_pkg::ST_PIO &&
						q.cls == acp_pkg::CLS_PIO_OUT) begin
						d.pio_wr = 1'h1;
						d.wdata = i_pwdata;
						word_go = 1'h1;
					end
				default: d.wdata = q.wdata;
			endcase
		end
		if (fire_rd) begin
			if (i_paddr == acp_pkg::OFS_STATUS) begin
				d.irq = 1'h0;
			end
			if (i_paddr == acp_pkg::OFS_DATA && q.st == acp_pkg::ST_PIO &&
				q.cls == acp_pkg::CLS_PIO_IN) begin
				d.pio_rd = 1'h1;
				word_go = 1'h1;
			end
		end
		unique case (q.st)
			acp_pkg::ST_IDLE: d.st = d.st;
			acp_pkg::ST_DECODE: begin
				d.cls = dec_cls;
				// Priority is passed on; the back end may reorder.
				d.hi = (dec_cls == acp_pkg::CLS_QDMA) &
					q.tf.count[acp_pkg::PRIO_POS];
				if (dec_cls == acp_pkg::CLS_NONE) begin
					d.err = 1'h1;
					d.busy = 1'h0;
					d.st = acp_pkg::ST_IDLE;
				end else begin
					d.cmd_valid = 1'h1;
					if (dec_cls == acp_pkg::CLS_PIO_IN ||
						dec_cls == acp_pkg::CLS_PIO_OUT) begin
						d.words = sector_words(q.tf.count);
						d.dreq = 1'h1;
						d.busy = 1'h0;
						d.st = acp_pkg::ST_PIO;
					end else if (dec_cls == acp_pkg::CLS_NODATA) begin
						d.st = acp_pkg::ST_EXEC;
					end else begin
						d.st = acp_pkg::ST_DMA;
					end
				end
			end
			acp_pkg::ST_EXEC, acp_pkg::ST_DMA:
				if (i_exec_done) begin
					d.err = i_exec_err;
					d.busy = 1'h0;
					d.st = acp_pkg::ST_IDLE;
				end
			acp_pkg::ST_PIO:
				if (word_go) begin
					d.words = q.words - 16'h0001;
					if (q.words == 16'h0001) begin
						d.dreq = 1'h0;
						d.st = acp_pkg::ST_IDLE;
					end
				end
		endcase
		// Raising the interrupt is placed after the status-read and command-write clears so it wins; the reset clear comes later.
		if (q.busy & ~d.busy) begin
			d.irq = 1'h1;
		end
		if (reset_evt) begin
			d.st = acp_pkg::ST_IDLE;
			d.tf = '0;
			d.cls = acp_pkg::CLS_NONE;
			d.hi = 1'h0;
			d.err = 1'h0;
			d.busy = 1'h0;
			d.dreq = 1'h0;
			d.irq = 1'h0;
			d.words = 16'h0000;
			d.cmd_valid = 1'h0;
			d.pio_rd = 1'h0;
			d.pio_wr = 1'h0;
			d.abort = q.st != acp_pkg::ST_IDLE;
		end
	end

	// Ready is low during reset and rises at the first edge after it.
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= acp_pkg::REGS_RST;
		end else begin
			q <= d;
		end
	end

	assign o_prdata = q.prdata;
	assign o_pready = q.pready;
	assign o_pslverr = q.pslverr;
	assign o_cmd_valid = q.cmd_valid;
	assign o_cmd = q.tf;
	assign o_cmd_class = q.cls;
	assign o_cmd_hi_prio = q.hi;
	assign o_pio_rd = q.pio_rd;
	assign o_pio_wr = q.pio_wr;
	assign o_pio_wdata = q.wdata;
	assign o_busy = q.busy;
	assign o_data_req = q.dreq;
	assign o_intrq = q.irq;
	assign o_abort = q.abort;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	busy_or_dreq_a: assert property (
		(q.st != acp_pkg::ST_IDLE) |-> (o_busy || o_data_req))
		else $error("busy and data request both low mid-command");
	busy_fall_irq_a: assert property (
		($fell(o_busy) && !o_abort) |-> o_intrq)
		else $error("busy fell without interrupt");
	stat_read_clr_a: assert property (
		(fire_rd && i_paddr == acp_pkg::OFS_STATUS && !(q.busy && !d.busy))
		|=> !o_intrq)
		else $error("status read left interrupt pending");
	cmd_write_clr_a: assert property (
		(fire_wr && i_paddr == acp_pkg::OFS_COMMAND) |=> !o_intrq)
		else $error("command write left interrupt pending");
	pio_words_a: assert property (
		(q.st == acp_pkg::ST_DECODE && !reset_evt &&
		(dec_cls == acp_pkg::CLS_PIO_IN || dec_cls == acp_pkg::CLS_PIO_OUT))
		|=> (q.words == sector_words(q.tf.count) && o_data_req && !o_busy))
		else $error("PIO phase did not load whole sectors");
	nodata_exec_a: assert property (
		(q.st == acp_pkg::ST_DECODE && !reset_evt &&
		dec_cls == acp_pkg::CLS_NODATA)
		|=> (q.st == acp_pkg::ST_EXEC && !o_data_req)[*1] ##0 o_cmd_valid)
		else $error("non-data command entered a data phase");
	dma_wait_a: assert property (
		(q.st == acp_pkg::ST_DECODE && !reset_evt &&
		dec_cls >= acp_pkg::CLS_DMA) |=> (q.st == acp_pkg::ST_DMA && o_busy))
		else $error("DMA command not held busy");
	queue_prio_a: assert property (
		(q.st == acp_pkg::ST_DECODE && !reset_evt &&
		dec_cls == acp_pkg::CLS_QDMA)
		|=> (o_cmd_hi_prio == q.tf.count[acp_pkg::PRIO_POS] &&
		o_cmd_class == acp_pkg::CLS_QDMA))
		else $error("queued priority bit not carried");
	diag_class_a: assert property (
		(q.st == acp_pkg::ST_DECODE && q.tf.opcode == acp_pkg::OP_DIAG)
		|-> dec_cls == acp_pkg::CLS_NODATA)
		else $error("diagnostic opcode misclassed");
	native_class_a: assert property (
		(q.st == acp_pkg::ST_DECODE && q.tf.opcode == acp_pkg::OP_NATIVE_EXT)
		|-> dec_cls == acp_pkg::CLS_NODATA)
		else $error("native max opcode misclassed");
	queue_mgmt_a: assert property (
		(q.st == acp_pkg::ST_DECODE && q.tf.opcode == acp_pkg::OP_QUEUE_MGMT)
		|-> dec_cls == acp_pkg::CLS_NODATA)
		else $error("queue management opcode misclassed");
	unknown_abort_a: assert property (
		(q.st == acp_pkg::ST_DECODE && !reset_evt &&
		dec_cls == acp_pkg::CLS_NONE)
		|=> (q.st == acp_pkg::ST_IDLE && q.err && !o_data_req && o_intrq))
		else $error("unknown opcode not aborted");

	pio_in_cov: cover property (q.st == acp_pkg::ST_PIO &&
		q.cls == acp_pkg::CLS_PIO_IN ##1 q.st == acp_pkg::ST_IDLE);
	pio_out_cov: cover property (q.st == acp_pkg::ST_PIO &&
		q.cls == acp_pkg::CLS_PIO_OUT ##1 q.st == acp_pkg::ST_IDLE);
	queued_cov: cover property (q.st == acp_pkg::ST_DMA && q.hi);
	abort_cov: cover property (o_abort);
endmodule : acp_ctrl

// ### verilog/acp_pkg.sv
// Constants and types shared by the ATA command protocol control block.
package acp_pkg;
	localparam int ADDR_W = 8;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_FEATURE = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_COMMAND = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_ALT_STATUS = 8'h10;
	localparam logic [7:0] OFS_INFO = 8'h14;
	localparam logic [7:0] OFS_CONTROL = 8'h18;
	localparam logic [7:0] OFS_DATA = 8'h1C;
	// Field positions.
	localparam int STAT_BUSY_POS = 7;
	localparam int STAT_READY_POS = 6;
	localparam int STAT_DREQ_POS = 3;
	localparam int STAT_ERR_POS = 0;
	localparam int INFO_PRIO_POS = 3;
	localparam int INFO_ABORT_POS = 4;
	localparam int CTRL_SRST_POS = 2;
	localparam int PRIO_POS = 7;
	// Protocol class codes.
	localparam logic [2:0] CLS_NONE = 3'h0;
	localparam logic [2:0] CLS_PIO_IN = 3'h1;
	localparam logic [2:0] CLS_PIO_OUT = 3'h2;
	localparam logic [2:0] CLS_NODATA = 3'h3;
	localparam logic [2:0] CLS_DMA = 3'h4;
	localparam logic [2:0] CLS_QDMA = 3'h5;
	// Opcodes and feature values that steer shared opcodes.
	localparam logic [7:0] OP_DIAG = 8'h90;
	localparam logic [7:0] OP_NATIVE_EXT = 8'h27;
	localparam logic [7:0] OP_DEV_CFG = 8'hB1;
	localparam logic [7:0] OP_SANITIZE = 8'hB4;
	localparam logic [7:0] OP_QUEUE_MGMT = 8'h63;
	localparam logic [7:0] OP_SMART = 8'hB0;
	localparam logic [15:0] FT_CFG_RESTORE = 16'h00C0;
	localparam logic [15:0] FT_CFG_FREEZE = 16'h00C1;
	localparam logic [15:0] FT_CFG_IDENT = 16'h00C2;
	localparam logic [15:0] FT_CFG_SET = 16'h00C3;
	localparam logic [15:0] FT_SAN_STATUS = 16'h0000;
	localparam logic [15:0] FT_SAN_CRYPTO = 16'h0011;
	localparam logic [15:0] FT_SAN_OVERWRITE = 16'h0014;
	localparam logic [15:0] FT_SAN_FREEZE = 16'h0020;
	// Sector geometry of PIO transfers.
	localparam int SECT_BYTES = 512;
	localparam int WORD_BYTES = 4;
	localparam int SECT_WORDS = SECT_BYTES / WORD_BYTES;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DECODE = 5'h02,
		ST_EXEC = 5'h04,
		ST_PIO = 5'h08,
		ST_DMA = 5'h10
	} acp_state_e;

	typedef struct packed {
		logic [15:0] feature;
		logic [15:0] count;
		logic [7:0] opcode;
	} acp_taskfile_s;

	typedef struct packed {
		acp_state_e st;
		acp_taskfile_s tf;
		logic [2:0] cls;
		logic hi;
		logic err;
		logic busy;
		logic dreq;
		logic rdy;
		logic irq;
		logic [15:0] words;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic cmd_valid;
		logic pio_rd;
		logic pio_wr;
		logic [31:0] wdata;
		logic abort;
	} acp_regs_s;

	localparam acp_regs_s REGS_RST = '{st: ST_IDLE, default: '0};
endpackage : acp_pkg

// ### verilog/acp_cmd_decode.sv
// Opcode and feature decoder giving the protocol class of a command.
`timescale 1ns/1ns
module acp_cmd_decode (
	input wire logic [7:0] i_opcode,
	input wire logic [15:0] i_feature,
	output logic [2:0] o_class
);
	// Alternate opcodes sit in the same case items as their primaries.
	function automatic logic [2:0] cls_of(input logic [7:0] op,
		input logic [15:0] ft);
		logic [2:0] c;
		c = acp_pkg::CLS_NONE;
		casez (op)
			8'hEC, 8'hE4, 8'h2F, 8'hC4, 8'h29, 8'h20, 8'h21, 8'h24,
			8'h2B, 8'h5C: c = acp_pkg::CLS_PIO_IN;
			8'h92, 8'h50, 8'hF6, 8'hF4, 8'hF1, 8'hF2, 8'h5E, 8'hE8,
			8'h3F, 8'hC5, 8'h39, 8'hCE, 8'h30, 8'h31, 8'h34,
			8'h3B: c = acp_pkg::CLS_PIO_OUT;
			8'hE5, 8'h98, 8'h51, 8'hE7, 8'hEA, 8'hE3, 8'h97, 8'hE1,
			8'h95, 8'h91, 8'hF8, 8'h40, 8'h41, 8'h42, 8'h1?, 8'hF3,
			8'hF5, 8'h7?, 8'hEF, 8'hF9, 8'h37, 8'hC6, 8'hE6, 8'h99,
			8'hE2, 8'h96, 8'hE0, 8'h94,
			8'h45: c = acp_pkg::CLS_NODATA;
			acp_pkg::OP_DIAG: c = acp_pkg::CLS_NODATA;
			acp_pkg::OP_NATIVE_EXT: c = acp_pkg::CLS_NODATA;
			acp_pkg::OP_QUEUE_MGMT: c = acp_pkg::CLS_NODATA;
			8'hC8, 8'hC9, 8'h25, 8'h47, 8'h2A, 8'h5D, 8'h5F, 8'hCA,
			8'hCB, 8'h35, 8'h3D, 8'h57,
			8'h3A: c = acp_pkg::CLS_DMA;
			8'h60, 8'h61: c = acp_pkg::CLS_QDMA;
			acp_pkg::OP_DEV_CFG: begin
				unique case (ft)
					acp_pkg::FT_CFG_RESTORE,
					acp_pkg::FT_CFG_FREEZE: c = acp_pkg::CLS_NODATA;
					acp_pkg::FT_CFG_IDENT: c = acp_pkg::CLS_PIO_IN;
					acp_pkg::FT_CFG_SET: c = acp_pkg::CLS_PIO_OUT;
					default: c = acp_pkg::CLS_NONE;
				endcase
			end
			acp_pkg::OP_SANITIZE: begin
				unique case (ft)
					acp_pkg::FT_SAN_STATUS, acp_pkg::FT_SAN_CRYPTO,
					acp_pkg::FT_SAN_OVERWRITE,
					acp_pkg::FT_SAN_FREEZE: c = acp_pkg::CLS_NODATA;
					default: c = acp_pkg::CLS_NONE;
				endcase
			end
			acp_pkg::OP_SMART: begin
				unique case (ft[7:0])
					8'hD0, 8'hD1, 8'hD5: c = acp_pkg::CLS_PIO_IN;
					8'hD6: c = acp_pkg::CLS_PIO_OUT;
					8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hD9, 8'hDA,
					8'hDB: c = acp_pkg::CLS_NODATA;
					default: c = acp_pkg::CLS_NONE;
				endcase
			end
			default: c = acp_pkg::CLS_NONE;
		endcase
		return c;
	endfunction : cls_of

	always_comb begin
		o_class = cls_of(i_opcode, i_feature);
	end
endmodule : acp_cmd_decode

// ### verif/acp_backend_model.sv
// Back end model that finishes commands and feeds PIO read words.
`timescale 1ns/1ns
module acp_backend_model (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_cmd_valid,
	input wire logic [2:0] i_cmd_class,
	input wire logic i_pio_rd,
	input wire logic i_hold,
	input wire logic i_err,
	input wire logic [3:0] i_delay,
	output logic o_exec_done,
	output logic o_exec_err,
	output logic [31:0] o_pio_rdata
);
	logic [15:0] idx;
	int wait_n;
	assign o_pio_rdata = {16'ha5a5, idx};
	// Hold stands for a back end that hangs, so only a reset ends it.
	always @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_exec_done <= 1'b0;
			o_exec_err <= 1'b0;
			wait_n <= -1;
			idx <= 16'h0000;
		end else begin
			o_exec_done <= 1'b0;
			o_exec_err <= 1'b0;
			if (i_pio_rd) idx <= idx + 16'h0001;
			if (i_cmd_valid) idx <= 16'h0000;
			if (i_hold) wait_n <= -1;
			else if (i_cmd_valid && i_cmd_class >= 3'h3)
				wait_n <= i_delay;
			else if (wait_n == 0) begin
				o_exec_done <= 1'b1;
				o_exec_err <= i_err;
				wait_n <= -1;
			end else if (wait_n > 0) wait_n <= wait_n - 1;
		end
	end
endmodule : acp_backend_model

// ### verif/ata_command_protocol_control_tb_top.sv
// Self-checking bench for the command protocol control block.
`timescale 1ns/1ns
module ata_command_protocol_control_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic comrst = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd, rdat, pio_wd, r, w;
	logic prdy, perr, done, xerr, cv, hi, prd_p, pwr_p, busy, dreq, irq, abt, e;
	logic [2:0] cls, c;
	logic [15:0] f;
	acp_pkg::acp_taskfile_s cmd;
	logic hold = 1'b0;
	logic err_req = 1'b0;
	logic [3:0] dly = 4'h0;
	int seed = 32'hc446;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	int n_abt = 0;
	int n_prd = 0;
	int n_pwr = 0;
	int a;
	logic [31:0] wq[$];
	logic [7:0] tops [25] = '{8'h90, 8'h27, 8'h63, 8'hb1, 8'hb1, 8'hb1,
		8'hb1, 8'hb4, 8'hb4, 8'hb4, 8'hb4, 8'hb0, 8'hb0, 8'hb0, 8'he5,
		8'h98, 8'he3, 8'h97, 8'hc8, 8'h25, 8'h60, 8'h61, 8'h20, 8'h2f,
		8'h30};
	logic [15:0] tfts [14] = '{16'h0000, 16'h0000, 16'h0000, 16'h00c0,
		16'h00c1, 16'h00c2, 16'h00c3, 16'h0000, 16'h0011, 16'h0014,
		16'h0020, 16'h00d0, 16'h00d6, 16'h00d8};

	always #2 clk = ~clk;

	acp_ctrl u_acp_ctrl (.i_core_clk(clk), .i_sys_rst(rst),
		.i_comreset(comrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .i_exec_done(done),
		.i_exec_err(xerr), .i_pio_rdata(rdat), .o_cmd_valid(cv),
		.o_cmd(cmd), .o_cmd_class(cls), .o_cmd_hi_prio(hi),
		.o_pio_rd(prd_p), .o_pio_wr(pwr_p), .o_pio_wdata(pio_wd),
		.o_busy(busy), .o_data_req(dreq), .o_intrq(irq), .o_abort(abt));

	acp_backend_model u_acp_backend_model (.i_core_clk(clk),
		.i_sys_rst(rst), .i_cmd_valid(cv), .i_cmd_class(cls),
		.i_pio_rd(prd_p), .i_hold(hold), .i_err(err_req),
		.i_delay(dly), .o_exec_done(done), .o_exec_err(xerr),
		.o_pio_rdata(rdat));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t value %h expected %h", $time, g, x);
		end
	endtask : chk_reg

	task automatic chk_sig(input logic g, input logic x);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t flag %b expected %b", $time, g, x);
		end
	endtask : chk_sig

	function automatic logic [2:0] exp_cls(input logic [7:0] o,
		input logic [15:0] t);
		case (o)
			8'h90, 8'h27, 8'h63, 8'hb4, 8'he5, 8'h98, 8'he3,
			8'h97: return 3'h3;
			8'hb1: return (t == 16'h00c2) ? 3'h1 :
				(t == 16'h00c3) ? 3'h2 : 3'h3;
			8'hb0: return (t == 16'h00d0) ? 3'h1 :
				(t == 16'h00d6) ? 3'h2 : 3'h3;
			8'hc8, 8'h25: return 3'h4;
			8'h60, 8'h61: return 3'h5;
			8'h20, 8'h2f: return 3'h1;
			8'h30: return 3'h2;
			default: return 3'h0;
		endcase
	endfunction : exp_cls

	// Request held from setup until pready is seen at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		pa <= ad;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the cycle ceiling ends a wait that never sees pready.
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0000_0000);
		chk_reg(r, x);
	endtask : rd

	task automatic issue(input logic [7:0] op, input logic [15:0] t,
		input logic [15:0] cn);
		// Alternate status is polled so a pending interrupt stays set.
		do begin
			apb(1'b0, acp_pkg::OFS_ALT_STATUS, 32'h0000_0000);
		end while (r[7:6] !== 2'b01 || r[3] !== 1'b0);
		apb(1'b1, acp_pkg::OFS_FEATURE, {16'h0000, t});
		apb(1'b1, acp_pkg::OFS_COUNT, {16'h0000, cn});
		apb(1'b1, acp_pkg::OFS_COMMAND, {24'h00_0000, op});
		#1;
		chk_sig(busy, 1'b1);
		chk_sig(irq, 1'b0);
		// An unknown opcode never shows valid; its busy falls instead.
		do begin
			@(posedge clk);
		end while (cv !== 1'b1 && busy === 1'b1);
		c = cls;
		chk_reg({cmd.feature, cmd.count}, {t, cn});
		chk_reg({24'h00_0000, cmd.opcode}, {24'h00_0000, op});
	endtask : issue

	// Leaving the interrupt pending lets the next command write clear it.
	task automatic finish_cmd(input logic x, input logic rs);
		while (busy !== 1'b0) begin
			@(posedge clk);
		end
		#1;
		chk_sig(irq, 1'b1);
		if (rs) begin
			rd(acp_pkg::OFS_STATUS, {24'h00_0000, 7'h20, x});
			@(posedge clk);
			#1;
			chk_sig(irq, 1'b0);
		end
	endtask : finish_cmd

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (abt === 1'b1) n_abt <= n_abt + 1;
		if (prd_p === 1'b1) n_prd <= n_prd + 1;
		if (pwr_p === 1'b1) begin
			n_pwr <= n_pwr + 1;
			chk_reg(pio_wd, wq.pop_front());
		end
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(acp_pkg::OFS_STATUS, 32'h0000_0040);
		rd(8'h40, 32'h0000_0000);
		chk_sig(e, 1'b1);
		for (int i = 0; i < 25; i++) begin
			dly <= 4'($random(seed));
			err_req <= 1'($random(seed));
			f = (i > 2 && i < 14) ? tfts[i] : 16'($random(seed));
			issue(tops[i], f, 16'h0001);
			chk_reg({29'h0, c}, {29'h0, exp_cls(tops[i], f)});
			if (c == 3'h1 || c == 3'h2)
				apb(1'b1, acp_pkg::OFS_CONTROL, 32'h0000_0004);
			else finish_cmd(err_req, i[0]);
		end
		issue(8'h88, 16'h0000, 16'h0001);
		chk_sig(dreq, 1'b0);
		rd(acp_pkg::OFS_STATUS, 32'h0000_0041);
		rd(acp_pkg::OFS_INFO, 32'h0000_0010);
		issue(8'h20, 16'h0000, 16'h0002);
		#1;
		chk_sig(dreq, 1'b1);
		for (int k = 0; k < 256; k++)
			rd(acp_pkg::OFS_DATA, {16'ha5a5, 16'(k)});
		repeat (2) @(posedge clk);
		#1;
		chk_sig(dreq, 1'b0);
		chk_reg(32'(n_prd), 32'h0000_0100);
		issue(8'h30, 16'h0000, 16'h0001);
		for (int k = 0; k < 128; k++) begin
			w = $random(seed);
			wq.push_back(w);
			apb(1'b1, acp_pkg::OFS_DATA, w);
		end
		repeat (2) @(posedge clk);
		#1;
		chk_sig(dreq, 1'b0);
		chk_reg(32'(n_pwr), 32'h0000_0080);
		issue(8'h60, 16'h0000, 16'h0080);
		chk_sig(hi, 1'b1);
		rd(acp_pkg::OFS_INFO, 32'h0000_000d);
		finish_cmd(err_req, 1'b1);
		issue(8'h61, 16'h0000, 16'h007f);
		chk_sig(hi, 1'b0);
		finish_cmd(err_req, 1'b1);
		a = n_abt;
		// A back end that never finishes is the fault that justifies reset.
		hold <= 1'b1;
		issue(8'hc8, 16'h0000, 16'h0001);
		apb(1'b1, acp_pkg::OFS_CONTROL, 32'h0000_0004);
		repeat (2) @(posedge clk);
		#1;
		chk_sig(busy, 1'b0);
		issue(8'h25, 16'h0000, 16'h0001);
		comrst <= 1'b1;
		@(posedge clk);
		comrst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_sig(busy, 1'b0);
		chk_sig(irq, 1'b0);
		chk_reg(32'(n_abt - a), 32'h0000_0002);
		hold <= 1'b0;
		end_of_test();
	end
endmodule : ata_command_protocol_control_tb_top
